// ### common/spcr_pkg.sv
/*
 Constants, field positions and types shared by the serial port configuration block.
 Assumes a 13-bit register address space reached over a sampled serial link.
*/
package spcr_pkg;
    localparam int ADDR_W = 13;
    localparam int BYTE_W = 8;
    localparam int INSTR_W = 16;
    localparam int RW_BIT = 15;
    localparam logic [4:0] INSTR_LAST = 5'h0f;
    localparam logic [4:0] BYTE_LAST = 5'h07;

    localparam logic [12:0] CFG_A_ADDR = 13'h0000;
    localparam logic [12:0] CFG_B_ADDR = 13'h0001;
    localparam logic [12:0] UPDATE_ADDR = 13'h000f;
    localparam logic [12:0] BUF_BASE_ADDR = 13'h0010;

    localparam int A_SOFT_RST_BIT = 7;
    localparam int A_LSB_BIT = 6;
    localparam int A_INC_BIT = 5;
    localparam int A_4W_BIT = 4;
    localparam int A_MIR_4W_BIT = 3;
    localparam int A_MIR_INC_BIT = 2;
    localparam int A_MIR_LSB_BIT = 1;
    localparam int A_MIR_RST_BIT = 0;
    localparam int B_READ_BUF_BIT = 5;
    localparam int B_KEEP_RST_BIT = 2;
    localparam int UPDATE_BIT = 0;

    localparam logic [7:0] CFG_A_RESET = 8'h00;
    localparam logic [7:0] CFG_B_RESET = 8'h00;
    localparam logic [7:0] BUF_RESET = 8'h00;
    localparam logic [7:0] CFG_A_STORE_MASK = 8'h7e;
    localparam logic [7:0] CFG_B_STORE_MASK = 8'h20;

    typedef struct packed {
        logic lsb_first;
        logic addr_inc;
        logic four_wire_enable;
    } spcr_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_INSTR = 3'b010,
        ST_DATA = 3'b100
    } spcr_state_t;
endpackage

// ### src/spcr_port.sv
/*
 Serial control port with its two configuration registers, the update strobe register
 and a small bank of buffered registers.
 Assumes the link pins are asynchronous and the link clock is at least 8x slower
 than clk_sys_in; eeprom_en_in and save_addr_in come from logic on clk_sys_in.
*/
// How it works
// - Soft reset bit resets, requests settings reload
// - Bit 6 picks LSB-first or MSB-first order
// - Bit 5 steps address up, else down
// - Bit 4 selects four-wire output pin
// - Low nibble mirrors high nibble, ORed
// - Controls ignored while in I2C mode
// - Configuration registers never saved to EEPROM
// - Read-buffer bit selects pending or active values
// - Keep-registers bit resets device, keeps contents
// - Update bit copies buffered into active, self-clears
module spcr_port #(
    parameter int NBUF = 4
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Serial link
    input wire logic sclk_in,
    input wire logic csn_in,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_out,
    output logic sdo_out,
    output logic sdo_oe_out,
    // Mode and device control
    input wire logic i2c_mode_in,
    input wire logic eeprom_en_in,
    output logic reload_req_out,
    output logic device_reset_out,
    output spcr_pkg::spcr_ctrl_t ctrl_out,
    output logic [NBUF*8-1:0] active_regs_out,
    // EEPROM save filter
    input wire logic [12:0] save_addr_in,
    output logic save_allow_out
);
    localparam int IDX_W = (NBUF > 1) ? $clog2(NBUF) : 1;

    function automatic logic [12:0] addr_step(input logic [12:0] a, input logic inc);
        addr_step = inc ? a + 13'h0001 : a - 13'h0001;
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb);
        shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
    endfunction

    logic [3:0] sync1_r, sync2_r;
    logic sclk_d_r;
    spcr_pkg::spcr_state_t state_r;
    logic [4:0] cnt_r;
    logic [15:0] instr_r;
    logic [7:0] byte_r, tx_r;
    logic [2:0] tx_idx_r;
    logic out_bit_r, rd_r;
    logic [12:0] addr_r;
    logic [7:0] cfg_a_r, cfg_b_r;
    logic [7:0] buf_r [NBUF];
    logic [7:0] act_r [NBUF];
    logic soft_rst_r, reload_r, dev_rst_r, save_allow_r;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    // Pins pass two flops; only sync2 is read by logic
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_r <= 4'h3;
            sync2_r <= 4'h3;
            sclk_d_r <= 1'b1;
        end else begin
            sync1_r <= {i2c_mode_in, sdio_in, csn_in, sclk_in};
            sync2_r <= sync1_r;
            sclk_d_r <= sync2_r[0];
        end
    end

    wire sclk_s = sync2_r[0];
    wire csn_s = sync2_r[1];
    wire sdio_s = sync2_r[2];
    wire i2c_s = sync2_r[3];
    wire rise = sclk_s & ~sclk_d_r;
    wire fall = ~sclk_s & sclk_d_r;

    // Mirrored pairs ORed so the pattern works in either bit order
    wire lsb_raw = cfg_a_r[spcr_pkg::A_LSB_BIT] | cfg_a_r[spcr_pkg::A_MIR_LSB_BIT];
    wire inc_raw = cfg_a_r[spcr_pkg::A_INC_BIT] | cfg_a_r[spcr_pkg::A_MIR_INC_BIT];
    wire four_raw = cfg_a_r[spcr_pkg::A_4W_BIT] | cfg_a_r[spcr_pkg::A_MIR_4W_BIT];
    assign ctrl_out.lsb_first = lsb_raw & ~i2c_s;
    assign ctrl_out.addr_inc = inc_raw & ~i2c_s;
    assign ctrl_out.four_wire_enable = four_raw & ~i2c_s;
    wire lsb = ctrl_out.lsb_first;

    wire in_instr = state_r == spcr_pkg::ST_INSTR;
    wire in_data = state_r == spcr_pkg::ST_DATA;
    wire [15:0] instr_nxt = lsb ? {sdio_s, instr_r[15:1]} : {instr_r[14:0], sdio_s};
    wire [7:0] byte_nxt = shift_in(byte_r, sdio_s, lsb);
    wire instr_done = rise & in_instr & (cnt_r == spcr_pkg::INSTR_LAST);
    wire byte_done = rise & in_data & (cnt_r == spcr_pkg::BYTE_LAST);
    wire [12:0] next_addr = addr_step(addr_r, ctrl_out.addr_inc);

    // Write decode
    wire wr_commit = byte_done & ~rd_r;
    wire wr_a = wr_commit & (addr_r == spcr_pkg::CFG_A_ADDR);
    wire wr_b = wr_commit & (addr_r == spcr_pkg::CFG_B_ADDR);
    wire wr_upd = wr_commit & (addr_r == spcr_pkg::UPDATE_ADDR);
    wire [12:0] wr_off = addr_r - spcr_pkg::BUF_BASE_ADDR;
    wire wr_buf = wr_commit & (addr_r >= spcr_pkg::BUF_BASE_ADDR) & (wr_off < 13'(NBUF));
    wire soft_req = wr_a & (byte_nxt[spcr_pkg::A_SOFT_RST_BIT] | byte_nxt[spcr_pkg::A_MIR_RST_BIT]);
    wire keep_req = wr_b & byte_nxt[spcr_pkg::B_KEEP_RST_BIT];
    wire upd_req = wr_upd & byte_nxt[spcr_pkg::UPDATE_BIT];

    // Read decode
    wire [12:0] rd_addr = instr_done ? instr_nxt[12:0] : next_addr;
    wire [12:0] rd_off = rd_addr - spcr_pkg::BUF_BASE_ADDR;
    wire rd_hit_buf = (rd_addr >= spcr_pkg::BUF_BASE_ADDR) & (rd_off < 13'(NBUF));
    wire [IDX_W-1:0] rd_idx = rd_off[IDX_W-1:0];
    wire [7:0] rd_buf = cfg_b_r[spcr_pkg::B_READ_BUF_BIT] ? buf_r[rd_idx] : act_r[rd_idx];
    wire [7:0] rd_data = (rd_addr == spcr_pkg::CFG_A_ADDR) ? cfg_a_r :
                         (rd_addr == spcr_pkg::CFG_B_ADDR) ? cfg_b_r :
                         rd_hit_buf ? rd_buf : 8'h00;
    wire load_tx = (instr_done & instr_nxt[spcr_pkg::RW_BIT]) | (byte_done & rd_r);

    // Frame sequencer; csn high always aborts
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= spcr_pkg::ST_IDLE;
            cnt_r <= 5'h00;
            instr_r <= 16'h0000;
            byte_r <= 8'h00;
            addr_r <= 13'h0000;
            rd_r <= 1'b0;
        end else if (csn_s) begin
            state_r <= spcr_pkg::ST_IDLE;
            cnt_r <= 5'h00;
        end else begin
            case (state_r)
                spcr_pkg::ST_IDLE: begin
                    state_r <= spcr_pkg::ST_INSTR;
                    cnt_r <= 5'h00;
                end
                spcr_pkg::ST_INSTR: begin
                    if (rise) begin
                        instr_r <= instr_nxt;
                        cnt_r <= instr_done ? 5'h00 : cnt_r + 5'h01;
                    end
                    if (instr_done) begin
                        state_r <= spcr_pkg::ST_DATA;
                        addr_r <= instr_nxt[12:0];
                        rd_r <= instr_nxt[spcr_pkg::RW_BIT];
                    end
                end
                spcr_pkg::ST_DATA: begin
                    if (rise) begin
                        byte_r <= byte_nxt;
                        cnt_r <= byte_done ? 5'h00 : cnt_r + 5'h01;
                    end
                    if (byte_done) begin
                        addr_r <= next_addr;
                    end
                end
                default: state_r <= spcr_pkg::ST_IDLE;
            endcase
        end
    end

    // Read shifter: new bit appears on each link falling edge
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_r <= 8'h00;
            tx_idx_r <= 3'h0;
            out_bit_r <= 1'b0;
        end else if (load_tx) begin
            tx_r <= rd_data;
            tx_idx_r <= 3'h0;
        end else if (fall & in_data & rd_r) begin
            out_bit_r <= lsb ? tx_r[tx_idx_r] : tx_r[~tx_idx_r];
            tx_idx_r <= tx_idx_r + 3'h1;
        end
    end

    wire drive = in_data & rd_r & ~csn_s;
    assign sdio_out = out_bit_r;
    assign sdo_out = out_bit_r;
    assign sdio_oe_out = drive & ~ctrl_out.four_wire_enable;
    assign sdo_oe_out = drive & ctrl_out.four_wire_enable;

    // Reset bits are never stored, so they read as zero and cannot re-fire
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_a_r <= spcr_pkg::CFG_A_RESET;
            cfg_b_r <= spcr_pkg::CFG_B_RESET;
        end else if (soft_rst_r) begin
            cfg_a_r <= spcr_pkg::CFG_A_RESET;
            cfg_b_r <= spcr_pkg::CFG_B_RESET;
        end else begin
            if (wr_a) begin
                cfg_a_r <= byte_nxt & spcr_pkg::CFG_A_STORE_MASK;
            end
            if (wr_b) begin
                cfg_b_r <= byte_nxt & spcr_pkg::CFG_B_STORE_MASK;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NBUF; g++) begin : g_bank
            always_ff @(posedge clk_sys_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    buf_r[g] <= spcr_pkg::BUF_RESET;
                    act_r[g] <= spcr_pkg::BUF_RESET;
                end else if (soft_rst_r) begin
                    buf_r[g] <= spcr_pkg::BUF_RESET;
                    act_r[g] <= spcr_pkg::BUF_RESET;
                end else begin
                    if (wr_buf && wr_off[IDX_W-1:0] == IDX_W'(g)) begin
                        buf_r[g] <= byte_nxt;
                    end
                    if (upd_req) begin
                        act_r[g] <= buf_r[g];
                    end
                end
            end
            assign active_regs_out[g*8 +: 8] = act_r[g];
        end
    endgenerate

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            soft_rst_r <= 1'b0;
            reload_r <= 1'b0;
            dev_rst_r <= 1'b0;
            save_allow_r <= 1'b0;
        end else begin
            soft_rst_r <= soft_req;
            reload_r <= soft_req & eeprom_en_in;
            dev_rst_r <= soft_req | keep_req;
            save_allow_r <= (save_addr_in != spcr_pkg::CFG_A_ADDR) & (save_addr_in != spcr_pkg::CFG_B_ADDR);
        end
    end
    assign reload_req_out = reload_r;
    assign device_reset_out = dev_rst_r;
    assign save_allow_out = save_allow_r;

    soft_reload_a: assert property (soft_req && eeprom_en_in |=> reload_req_out && device_reset_out
        ##1 cfg_a_r == spcr_pkg::CFG_A_RESET)
        else $error("soft reset did not reload and clear");
    order_out_a: assert property (fall && in_data && rd_r && !load_tx && tx_idx_r == 3'h0
        |=> sdio_out == ($past(lsb) ? $past(tx_r[0]) : $past(tx_r[7])))
        else $error("first read bit in wrong order");
    addr_step_a: assert property (byte_done && !csn_s |=>
        addr_r == ($past(ctrl_out.addr_inc) ? $past(addr_r) + 13'h0001 : $past(addr_r) - 13'h0001))
        else $error("address step wrong");
    wire_sel_a: assert property (drive |-> (sdo_oe_out == ctrl_out.four_wire_enable) && (sdio_oe_out != sdo_oe_out))
        else $error("wrong data pin driven");
    mirror_or_a: assert property (wr_a && byte_nxt[spcr_pkg::A_MIR_LSB_BIT] && !i2c_s |=> ctrl_out.lsb_first)
        else $error("mirror bit not honoured");
    i2c_mask_a: assert property (i2c_s |-> !ctrl_out.lsb_first && !ctrl_out.addr_inc && !ctrl_out.four_wire_enable)
        else $error("controls active in I2C mode");
    save_excl_a: assert property (save_addr_in == spcr_pkg::CFG_A_ADDR || save_addr_in == spcr_pkg::CFG_B_ADDR
        |=> !save_allow_out)
        else $error("config register allowed into save");
    read_buf_a: assert property (instr_done && instr_nxt[spcr_pkg::RW_BIT]
        && instr_nxt[12:0] == spcr_pkg::BUF_BASE_ADDR
        |=> tx_r == ($past(cfg_b_r[spcr_pkg::B_READ_BUF_BIT]) ? $past(buf_r[0]) : $past(act_r[0])))
        else $error("read buffer select wrong");
    keep_rst_a: assert property (keep_req && !soft_req |=> device_reset_out && !soft_rst_r ##1 !device_reset_out)
        else $error("keep reset pulse wrong");
    update_copy_a: assert property (upd_req && !soft_rst_r |=> act_r[0] == $past(buf_r[0]))
        else $error("update did not copy");
    self_clear_a: assert property (wr_commit |=> !cfg_a_r[7] && !cfg_a_r[0] && !cfg_b_r[2])
        else $error("reset bit did not self clear");

    read_seen_c: cover property (load_tx ##[1:200] byte_done && rd_r);
    update_seen_c: cover property (upd_req);
    soft_seen_c: cover property (soft_req && eeprom_en_in);
    four_wire_c: cover property (sdo_oe_out);
endmodule // spcr_port

// ### tb/spcr_host.sv
/*
 Host controller model that frames transfers on the serial link of spcr_port.
 Assumes clk_in is the bench system clock; pins change on its falling edge.
*/
module spcr_host (
    input wire logic clk_in,
    input wire logic sdio_wire_in,
    input wire logic sdo_wire_in,
    output logic sclk_out,
    output logic csn_out,
    output logic sdio_drv_out,
    output logic rel_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Link clock stands high between frames
    initial begin
        sclk_out = 1'b1;
        csn_out = 1'b1;
        sdio_drv_out = 1'b0;
        rel_out = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // Long low phase leaves room for the device's sync delay before sampling
    task automatic xfer(input logic rd, input logic [12:0] addr, input logic lsb, input logic fw,
                        input int nb, input logic [15:0] wdat, output logic [15:0] rdat);
        logic [15:0] ins;
        int i;
        int k;
        ins = {rd, 2'b00, addr};
        rdat = 16'h0000;
        @(negedge clk_in);
        csn_out = 1'b0;
        for (i = 0; i < 16 + 8 * nb; i++) begin
            sclk_out = 1'b0;
            // Shared pin let go while the device answers in 3-wire mode
            rel_out = rd & ~fw & (i >= 16);
            k = (i < 16) ? i : i - 16;
            if (i < 16)
                sdio_drv_out = lsb ? ins[k] : ins[15 - k];
            else
                sdio_drv_out = lsb ? wdat[k] : wdat[8 * (k / 8) + 7 - k % 8];
            wait_n(5);
            if (i >= 16)
                rdat[lsb ? k : 8 * (k / 8) + 7 - k % 8] = fw ? sdo_wire_in : sdio_wire_in;
            sclk_out = 1'b1;
            wait_n(3);
        end
        wait_n(4);
        csn_out = 1'b1;
        rel_out = 1'b0;
        wait_n(8);
    endtask
endmodule // spcr_host

// ### tb/spcr_port_bench.sv
/*
 Self-checking bench for spcr_port with a host model on the serial link.
 Assumes the design package is compiled first.
*/
module spcr_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in, rstn_in, sclk, csn, drv, rel, i2c, ee, sdio_o, sdio_oe, sdo_o, sdo_oe, reload, devrst, allow;
    spcr_pkg::spcr_ctrl_t ctrl;
    logic [31:0] act;
    logic [12:0] save_addr;
    logic [15:0] rd, d, e;
    logic [7:0] v;
    int err_total, cmp_count, n_reload, n_rst, i;
    // Undriven data lines show the inverse of the device's bit, so a missing enable cannot pass
    wire sdio_w = sdio_oe ? sdio_o : (rel ? ~sdio_o : drv);
    wire sdo_w = sdo_oe ? sdo_o : ~sdo_o;

    spcr_port #(.NBUF(4)) i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .sclk_in(sclk), .csn_in(csn),
        .sdio_in(sdio_w), .sdio_out(sdio_o), .sdio_oe_out(sdio_oe), .sdo_out(sdo_o), .sdo_oe_out(sdo_oe),
        .i2c_mode_in(i2c), .eeprom_en_in(ee), .reload_req_out(reload), .device_reset_out(devrst),
        .ctrl_out(ctrl), .active_regs_out(act), .save_addr_in(save_addr), .save_allow_out(allow));
    spcr_host i_host (.clk_in(clk_sys_in), .sdio_wire_in(sdio_w), .sdo_wire_in(sdo_w), .sclk_out(sclk),
        .csn_out(csn), .sdio_drv_out(drv), .rel_out(rel));

    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    // Pulses counted mid-cycle, clear of the edge that launches them
    always @(negedge clk_sys_in) begin
        if (reload === 1'b1)
            n_reload++;
        if (devrst === 1'b1)
            n_rst++;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic lsb, input int nb, input logic [15:0] w);
        i_host.xfer(1'b0, a, lsb, 1'b0, nb, w, rd);
    endtask

    task automatic rdchk(input string what, input logic [12:0] a, input logic lsb, input logic fw,
                         input logic [7:0] exp);
        i_host.xfer(1'b1, a, lsb, fw, 1, 16'haaaa, rd);
        check(what, rd[7:0], exp);
    endtask

    task tally_and_finish;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk_sys_in);
        err_total++;
        tally_and_finish;
    end

    initial begin
        rstn_in = 1'b0;
        i2c = 1'b0;
        ee = 1'b0;
        save_addr = 13'h0000;
        void'($urandom(32'h9f3d14b7));
        repeat (8) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        rdchk("cfg_a reset", 13'h0000, 1'b0, 1'b0, 8'h00);
        rdchk("cfg_b reset", 13'h0001, 1'b0, 1'b0, 8'h00);
        for (i = 0; i < 4; i++) begin
            v = 8'($urandom) & 8'h3c;
            wr(13'h0000, 1'b0, 1, {8'h00, v});
            check("ctrl", 32'(ctrl), {29'h0, 1'b0, v[5] | v[2], v[4] | v[3]});
            rdchk("cfg_a", 13'h0000, 1'b0, v[4] | v[3], v);
            i2c = 1'b1;
            repeat (4) @(negedge clk_sys_in);
            check("ctrl i2c", 32'(ctrl), 32'h0);
            i2c = 1'b0;
        end
        d = 16'($urandom);
        e = 16'($urandom);
        wr(13'h0000, 1'b0, 1, 16'h0024);
        wr(13'h0010, 1'b0, 2, d);
        wr(13'h0000, 1'b0, 1, 16'h0000);
        wr(13'h0013, 1'b0, 2, e);
        rdchk("active", 13'h0010, 1'b0, 1'b0, 8'h00);
        wr(13'h0001, 1'b0, 1, 16'h0020);
        rdchk("buf10", 13'h0010, 1'b0, 1'b0, d[7:0]);
        rdchk("buf11", 13'h0011, 1'b0, 1'b0, d[15:8]);
        rdchk("buf12", 13'h0012, 1'b0, 1'b0, e[15:8]);
        wr(13'h000f, 1'b0, 1, 16'h0001);
        check("update", act, {e[7:0], e[15:8], d[15:8], d[7:0]});
        rdchk("update rd", 13'h000f, 1'b0, 1'b0, 8'h00);
        // Mirrored pattern reads the same in either order
        wr(13'h0000, 1'b0, 1, 16'h0042);
        check("lsb ctrl", 32'(ctrl), 32'h4);
        v = 8'($urandom);
        wr(13'h0010, 1'b1, 1, {8'h00, v});
        rdchk("lsb buf", 13'h0010, 1'b1, 1'b0, v);
        rdchk("lsb cfg", 13'h0000, 1'b1, 1'b0, 8'h42);
        ee = 1'b1;
        wr(13'h0000, 1'b1, 1, 16'h0081);
        check("reload", n_reload, 1);
        check("reset", n_rst, 1);
        check("act cleared", act, 32'h0);
        rdchk("cfg_a after", 13'h0000, 1'b0, 1'b0, 8'h00);
        ee = 1'b0;
        wr(13'h0000, 1'b0, 1, 16'h003c);
        wr(13'h0011, 1'b0, 1, {8'h00, v});
        wr(13'h000f, 1'b0, 1, 16'h0001);
        wr(13'h0001, 1'b0, 1, 16'h0004);
        check("keep reset", n_rst, 2);
        check("keep reload", n_reload, 1);
        check("keep act", act, {16'h0, v, 8'h00});
        check("keep ctrl", 32'(ctrl), 32'h3);
        rdchk("cfg_b after", 13'h0001, 1'b0, 1'b1, 8'h00);
        // In I2C mode the port falls back to MSB first on three wires
        i2c = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        rdchk("i2c rd", 13'h0011, 1'b0, 1'b0, v);
        i2c = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        for (i = 0; i < 6; i++) begin
            save_addr = (i < 2) ? 13'(i) : 13'($urandom_range(8191, 2));
            @(negedge clk_sys_in);
            check("save_allow", 32'(allow), 32'(i >= 2));
        end
        tally_and_finish;
    end
endmodule // spcr_port_bench
